// ==== design/serial_nine_bit_data_regs.sv ====
// Data registers, mode decode and transmit FIFO of an asynchronous serial channel.
// Assumes a same-clock register master; the shifter sits outside and drains the FIFO.
`timescale 1ns/100ps
`include "serial_nine_bit_regs.svh"

module word_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk_i,
  input  wire logic             reset_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic             push;
  logic             pop;
  if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("word_fifo needs a width and a power-of-two depth");
  end
  assign in_ready_o  = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push = in_valid_i && in_ready_o;
  assign pop  = out_valid_o && out_ready_i;
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end
endmodule : word_fifo

////////////////////////////////////////////////////////////////////////////////
// What this block does
// [R1] Received character held in high/low bytes
// [R2] Both receive halves readable as one word
// [R3] Transmit character written via high/low bytes
// [R4] Both transmit halves writable as one word
// [R5] Mode bit: 0 asynchronous, 1 synchronous/SPI
// [R6] Async length: 00/01 nine, 10 eight, 11 seven
// [R7] Ninth bit sits in high register bit 0
module serial_nine_bit_data_regs #(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        core_clk_i,
  input  wire logic        reset_i,
  input  wire logic [3:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [15:0] rdata_o,
  input  wire logic        rx_valid_i,
  input  wire logic [8:0]  rx_char_i,
  output logic             tx_valid_o,
  input  wire logic        tx_ready_i,
  output logic      [8:0]  tx_char_o,
  output logic             sync_mode_o,
  output logic      [1:0]  char_len_o
);
  logic [7:0]  mode_cfg_q;
  logic [7:0]  card_cfg_q;
  logic [7:0]  rx_high_q;
  logic [7:0]  rx_low_q;
  logic [7:0]  tx_high_q;
  logic [7:0]  tx_low_q;
  logic [15:0] rdata_q;
  logic        tx_push_q;
  logic        tx_valid_q;
  logic [8:0]  tx_char_q;
  logic        sync_q;
  logic [1:0]  len_q;
  logic        fifo_in_ready;
  logic        fifo_out_valid;
  logic [8:0]  fifo_out_data;
  logic        take_out;
  serial_nine_bit_pkg::char_len_type len_d;

  // Pointers wrap by bit width, so only powers of two serve
  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_fifo_depth
    $error("FIFO_DEPTH must be a power of two");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration registers
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      mode_cfg_q <= `MODE_CONFIG_RESET;
      card_cfg_q <= `CARD_MODE_RESET;
    end else if (wr_i) begin
      if (addr_i == `ADDR_MODE_CONFIG) mode_cfg_q <= wdata_i[7:0];
      if (addr_i == `ADDR_CARD_MODE) card_cfg_q <= wdata_i[7:0];
    end
  end

  // Length decode only meaningful while asynchronous
  // Not gated by mode: synchronous framing is fixed by the shifter
  always_comb begin
    unique case ({card_cfg_q[`CARD_CHAR_HIGH_BIT], mode_cfg_q[`CFG_CHAR_LOW_BIT]})
      2'b00, 2'b01: len_d = serial_nine_bit_pkg::len_nine_type; // R6
      2'b10:        len_d = serial_nine_bit_pkg::len_eight_type; // R6
      2'b11:        len_d = serial_nine_bit_pkg::len_seven_type; // R6
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      sync_q <= 1'b0;
      len_q  <= 2'b00;
    end else begin
      sync_q <= mode_cfg_q[`CFG_COMM_MODE_BIT]; // R5
      len_q  <= len_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Receive capture; lengths under nine clear the unused bits
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rx_high_q <= 8'h00;
      rx_low_q  <= 8'h00;
    end else if (rx_valid_i) begin
      rx_high_q <= {7'h00, rx_char_i[`WORD_NINTH_BIT] &&
                    len_d == serial_nine_bit_pkg::len_nine_type}; // R1 R7
      rx_low_q  <= (len_d == serial_nine_bit_pkg::len_seven_type) ?
                   {1'b0, rx_char_i[6:0]} : rx_char_i[7:0]; // R1
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit holding; the low byte or word write commits the character
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      tx_high_q <= 8'h00;
      tx_low_q  <= 8'h00;
      tx_push_q <= 1'b0;
    end else begin
      tx_push_q <= 1'b0;
      if (wr_i && addr_i == `ADDR_TX_DATA_HIGH) begin
        tx_high_q <= {7'h00, wdata_i[`NINTH_BIT_POS]}; // R3 R7
      end
      if (wr_i && addr_i == `ADDR_TX_DATA_LOW) begin
        tx_low_q  <= wdata_i[7:0]; // R3
        tx_push_q <= 1'b1;
      end
      if (wr_i && addr_i == `ADDR_TX_DATA_WORD) begin
        tx_high_q <= {7'h00, wdata_i[`WORD_NINTH_BIT]}; // R4 R7
        tx_low_q  <= wdata_i[7:0]; // R4
        tx_push_q <= 1'b1;
      end
    end
  end

  // Full FIFO drops the push; software checks the status bit first
  word_fifo #(
    .WIDTH (9),
    .DEPTH (FIFO_DEPTH)
  ) tx_fifo (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .in_valid_i  (tx_push_q),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   ({tx_high_q[`NINTH_BIT_POS], tx_low_q}),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (take_out),
    .out_data_o  (fifo_out_data)
  );

  // Registered output stage so the shifter sees flops only
  // Costs one extra slot: stage plus FIFO hold depth plus one
  assign take_out = fifo_out_valid && (!tx_valid_q || tx_ready_i);
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      tx_valid_q <= 1'b0;
      tx_char_q  <= 9'h000;
    end else if (take_out) begin
      tx_valid_q <= 1'b1;
      tx_char_q  <= fifo_out_data;
    end else if (tx_ready_i) begin
      tx_valid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port, data one cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (reset_i) begin
      rdata_q <= 16'h0000;
    end else if (rd_i) begin
      case (addr_i)
        `ADDR_RX_DATA_HIGH: rdata_q <= {8'h00, rx_high_q}; // R1
        `ADDR_RX_DATA_LOW:  rdata_q <= {8'h00, rx_low_q}; // R1
        `ADDR_RX_DATA_WORD: rdata_q <= {rx_high_q, rx_low_q}; // R2
        `ADDR_TX_DATA_HIGH: rdata_q <= {8'h00, tx_high_q};
        `ADDR_TX_DATA_LOW:  rdata_q <= {8'h00, tx_low_q};
        `ADDR_TX_DATA_WORD: rdata_q <= {tx_high_q, tx_low_q};
        `ADDR_MODE_CONFIG:  rdata_q <= {8'h00, mode_cfg_q};
        `ADDR_CARD_MODE:    rdata_q <= {8'h00, card_cfg_q};
        `ADDR_STATUS:       rdata_q <= {11'h000, len_q, sync_q, fifo_out_valid, fifo_in_ready};
        default:            rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  assign rdata_o     = rdata_q;
  assign tx_valid_o  = tx_valid_q;
  assign tx_char_o   = tx_char_q;
  assign sync_mode_o = sync_q;
  assign char_len_o  = len_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  // Receive side
  a_rx_high_read: assert property (@(posedge core_clk_i) disable iff (reset_i) // R1
    rd_i && addr_i == `ADDR_RX_DATA_HIGH |=> rdata_o == {8'h00, $past(rx_high_q)})
    else $error("receive high read wrong");
  a_rx_low_read: assert property (@(posedge core_clk_i) disable iff (reset_i) // R1
    rd_i && addr_i == `ADDR_RX_DATA_LOW |=> rdata_o == {8'h00, $past(rx_low_q)})
    else $error("receive low read wrong");
  a_rx_held: assert property (@(posedge core_clk_i) disable iff (reset_i) // R1
    !rx_valid_i |=> $stable(rx_high_q) && $stable(rx_low_q))
    else $error("receive data changed without a character");
  a_rx_word_read: assert property (@(posedge core_clk_i) disable iff (reset_i) // R2
    rd_i && addr_i == `ADDR_RX_DATA_WORD |=> rdata_o == {$past(rx_high_q), $past(rx_low_q)})
    else $error("receive word read wrong");
  a_ninth_bit: assert property (@(posedge core_clk_i) disable iff (reset_i) // R7
    rx_valid_i && len_d == serial_nine_bit_pkg::len_nine_type
      |=> rx_high_q == {7'h00, $past(rx_char_i[`WORD_NINTH_BIT])})
    else $error("ninth bit misplaced");
  a_seven_trim: assert property (@(posedge core_clk_i) disable iff (reset_i) // R6
    rx_valid_i && len_d == serial_nine_bit_pkg::len_seven_type
      |=> !rx_low_q[7] && rx_high_q == 8'h00)
    else $error("seven bit character not trimmed");

  ////////////////////////////////////////////////////////////////////////////////
  // Transmit side
  a_tx_high_write: assert property (@(posedge core_clk_i) disable iff (reset_i) // R3
    wr_i && addr_i == `ADDR_TX_DATA_HIGH
      |=> tx_high_q == {7'h00, $past(wdata_i[`NINTH_BIT_POS])})
    else $error("transmit high write wrong");
  a_tx_high_alone: assert property (@(posedge core_clk_i) disable iff (reset_i) // R3
    wr_i && addr_i == `ADDR_TX_DATA_HIGH |=> !tx_push_q)
    else $error("transmit high write sent a character");
  a_tx_low_push: assert property (@(posedge core_clk_i) disable iff (reset_i) // R3
    wr_i && addr_i == `ADDR_TX_DATA_LOW |=> tx_push_q && tx_low_q == $past(wdata_i[7:0]))
    else $error("transmit low write lost");
  a_tx_word_write: assert property (@(posedge core_clk_i) disable iff (reset_i) // R4
    wr_i && addr_i == `ADDR_TX_DATA_WORD |=> tx_high_q == {7'h00, $past(wdata_i[`WORD_NINTH_BIT])})
    else $error("transmit word write wrong");
  a_tx_word_read: assert property (@(posedge core_clk_i) disable iff (reset_i) // R4
    rd_i && addr_i == `ADDR_TX_DATA_WORD |=> rdata_o == {$past(tx_high_q), $past(tx_low_q)})
    else $error("transmit word read wrong");
  a_tx_offer_held: assert property (@(posedge core_clk_i) disable iff (reset_i) // R3
    tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_char_o))
    else $error("transmit character dropped before accept");

  ////////////////////////////////////////////////////////////////////////////////
  // Mode and length
  a_cfg_reset: assert property (@(posedge core_clk_i) // R5
    reset_i |=> mode_cfg_q == `MODE_CONFIG_RESET && card_cfg_q == `CARD_MODE_RESET)
    else $error("configuration reset value wrong");
  a_mode_select: assert property (@(posedge core_clk_i) disable iff (reset_i) // R5
    ##1 sync_mode_o == $past(mode_cfg_q[`CFG_COMM_MODE_BIT]))
    else $error("mode select mismatch");
  a_len_seven: assert property (@(posedge core_clk_i) disable iff (reset_i) // R6
    card_cfg_q[`CARD_CHAR_HIGH_BIT] && mode_cfg_q[`CFG_CHAR_LOW_BIT]
      |=> char_len_o == serial_nine_bit_pkg::len_seven_type)
    else $error("seven bit decode wrong");
  a_len_eight: assert property (@(posedge core_clk_i) disable iff (reset_i) // R6
    card_cfg_q[`CARD_CHAR_HIGH_BIT] && !mode_cfg_q[`CFG_CHAR_LOW_BIT]
      |=> char_len_o == serial_nine_bit_pkg::len_eight_type)
    else $error("eight bit decode wrong");
  a_len_nine: assert property (@(posedge core_clk_i) disable iff (reset_i) // R6
    !card_cfg_q[`CARD_CHAR_HIGH_BIT] |=> char_len_o == serial_nine_bit_pkg::len_nine_type)
    else $error("nine bit decode wrong");
  a_status_mode: assert property (@(posedge core_clk_i) disable iff (reset_i) // R6
    rd_i && addr_i == `ADDR_STATUS
      |=> rdata_o[4:3] == $past(len_q) && rdata_o[2] == $past(sync_q))
    else $error("status length or mode wrong");

  // Main scenarios
  c_word_write: cover property (@(posedge core_clk_i) wr_i && addr_i == `ADDR_TX_DATA_WORD);
  c_fifo_full: cover property (@(posedge core_clk_i) !fifo_in_ready);
  c_tx_out: cover property (@(posedge core_clk_i) tx_valid_o && tx_ready_i);
  c_rx_word: cover property (@(posedge core_clk_i) rd_i && addr_i == `ADDR_RX_DATA_WORD);
  c_seven_rx: cover property (@(posedge core_clk_i)
    rx_valid_i && len_d == serial_nine_bit_pkg::len_seven_type);
endmodule : serial_nine_bit_data_regs

// ==== design/serial_nine_bit_regs.svh ====
// Register offsets, field positions and reset values for the serial data-register front end.
// Assumes inclusion by bare name from design files.
`ifndef SERIAL_NINE_BIT_REGS_SVH
`define SERIAL_NINE_BIT_REGS_SVH
`define ADDR_RX_DATA_HIGH    4'h0
`define ADDR_RX_DATA_LOW     4'h1
`define ADDR_RX_DATA_WORD    4'h2
`define ADDR_TX_DATA_HIGH    4'h3
`define ADDR_TX_DATA_LOW     4'h4
`define ADDR_TX_DATA_WORD    4'h5
`define ADDR_MODE_CONFIG     4'h6
`define ADDR_CARD_MODE       4'h7
`define ADDR_STATUS          4'h8
`define CFG_COMM_MODE_BIT    7
`define CFG_CHAR_LOW_BIT     6
`define CARD_CHAR_HIGH_BIT   4
`define MODE_CONFIG_RESET    8'h00
`define CARD_MODE_RESET      8'h10
`define NINTH_BIT_POS        0
`define WORD_NINTH_BIT       8
`endif

// ==== design/serial_nine_bit_pkg.sv ====
// Types shared by the serial data-register front end.
// Assumes the register header is included where offsets are needed.
package serial_nine_bit_pkg;
  typedef enum logic [1:0] {
    len_nine_type  = 2'b00,
    len_eight_type = 2'b01,
    len_seven_type = 2'b10
  } char_len_type;
endpackage : serial_nine_bit_pkg

// ==== tb/serial_nine_bit_data_regs_tb.sv ====
// Self-checking bench for the serial data-register front end.
// Assumes the design files and register header are compiled before it.
`timescale 1ns/100ps
`include "serial_nine_bit_regs.svh"

module serial_nine_bit_data_regs_tb;
  logic        core_clk_i  = 1'b0;
  logic        reset_i     = 1'b1;
  logic [3:0]  addr_i      = 4'h0;
  logic [15:0] wdata_i     = 16'h0000;
  logic        wr_i        = 1'b0;
  logic        rd_i        = 1'b0;
  logic [15:0] rdata_o;
  logic        rx_valid_i  = 1'b0;
  logic [8:0]  rx_char_i   = 9'h000;
  logic        tx_valid_o;
  logic        tx_ready_i  = 1'b0;
  logic [8:0]  tx_char_o;
  logic        sync_mode_o;
  logic [1:0]  char_len_o;
  int          err_count   = 0;
  int          checks_done = 0;
  logic [8:0]  exp_q[$];

  serial_nine_bit_data_regs #(.FIFO_DEPTH(8)) u_serial_nine_bit_data_regs (
    .core_clk_i  (core_clk_i),
    .reset_i     (reset_i),
    .addr_i      (addr_i),
    .wdata_i     (wdata_i),
    .wr_i        (wr_i),
    .rd_i        (rd_i),
    .rdata_o     (rdata_o),
    .rx_valid_i  (rx_valid_i),
    .rx_char_i   (rx_char_i),
    .tx_valid_o  (tx_valid_o),
    .tx_ready_i  (tx_ready_i),
    .tx_char_o   (tx_char_o),
    .sync_mode_o (sync_mode_o),
    .char_len_o  (char_len_o)
  );

  initial begin
    forever #25 core_clk_i = ~core_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Mismatches %0d, comparisons %0d", err_count, checks_done);
    if (err_count == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : complete_run

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("BAD at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge core_clk_i);
    wr_i    <= 1'b1;
    addr_i  <= a;
    wdata_i <= d;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the taking edge
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge core_clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    chk(rdata_o, exp, "read data");
  endtask : rd

  task automatic rx_put(input logic [8:0] c);
    @(posedge core_clk_i);
    rx_valid_i <= 1'b1;
    rx_char_i  <= c;
    @(posedge core_clk_i);
    rx_valid_i <= 1'b0;
  endtask : rx_put

  // Shifter stalls one edge after seeing each offer; two stall cycles between accepts
  task automatic tx_take(input logic [8:0] exp);
    int n;
    n = 0;
    while (tx_valid_o !== 1'b1 && n < 20) begin
      @(posedge core_clk_i);
      #1;
      n++;
    end
    if (tx_valid_o !== 1'b1) begin
      err_count++;
      $display("BAD at %0t: transmit character never offered", $time);
      complete_run();
    end else begin
      chk({7'h00, tx_char_o}, {7'h00, exp}, "tx char");
      @(posedge core_clk_i);
      tx_ready_i <= 1'b1;
      @(posedge core_clk_i);
      tx_ready_i <= 1'b0;
      @(posedge core_clk_i);
      #1;
    end
  endtask : tx_take

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [1:0] lenv;
    logic [7:0] lo;
    logic       hi;
    repeat (20) @(posedge core_clk_i);
    reset_i <= 1'b0;
    rd(`ADDR_MODE_CONFIG, 16'h0000);
    rd(`ADDR_CARD_MODE, 16'h0010);
    rd(`ADDR_STATUS, 16'h0009);
    chk({14'h0000, char_len_o}, 16'h0001, "reset length");
    wr(`ADDR_MODE_CONFIG, 16'h0080);
    rd(`ADDR_MODE_CONFIG, 16'h0080);
    chk({15'h0000, sync_mode_o}, 16'h0001, "sync mode");
    wr(`ADDR_MODE_CONFIG, 16'h0000);
    rd(`ADDR_MODE_CONFIG, 16'h0000);
    chk({15'h0000, sync_mode_o}, 16'h0000, "async mode");
    // Every length code, receive path seen through all three views
    for (int i = 0; i < 4; i++) begin
      lenv = (i < 2) ? 2'h0 : 2'(i - 1);
      hi   = (i < 2);
      lo   = (i == 3) ? 8'h55 : 8'hd5;
      wr(`ADDR_CARD_MODE, {11'h000, i[1], 4'h0});
      wr(`ADDR_MODE_CONFIG, {9'h000, i[0], 6'h00});
      rx_put(9'h1d5);
      rd(`ADDR_STATUS, {11'h000, lenv, 3'h1});
      chk({14'h0000, char_len_o}, {14'h0000, lenv}, "length");
      rd(`ADDR_RX_DATA_HIGH, {15'h0000, hi});
      rd(`ADDR_RX_DATA_LOW, {8'h00, lo});
      rd(`ADDR_RX_DATA_WORD, {7'h00, hi, lo});
    end
    wr(`ADDR_CARD_MODE, 16'h0000);
    wr(`ADDR_MODE_CONFIG, 16'h0000);
    wr(`ADDR_TX_DATA_HIGH, 16'h00ff);
    rd(`ADDR_TX_DATA_HIGH, 16'h0001);
    rd(`ADDR_TX_DATA_LOW, 16'h0000);
    chk({15'h0000, tx_valid_o}, 16'h0000, "high alone sent");
    wr(`ADDR_TX_DATA_LOW, 16'h003c);
    rd(`ADDR_TX_DATA_WORD, 16'h013c);
    exp_q.push_back(9'h13c);
    // Output stage plus eight FIFO slots hold nine; the tenth push is dropped
    for (int k = 1; k < 10; k++) begin
      wr(`ADDR_TX_DATA_WORD, {7'h00, k[0], 8'h10 + 8'(k)});
      if (k < 9) exp_q.push_back({k[0], 8'h10 + 8'(k)});
    end
    rd(`ADDR_STATUS, 16'h0002);
    foreach (exp_q[j]) tx_take(exp_q[j]);
    rd(`ADDR_STATUS, 16'h0001);
    complete_run();
  end
endmodule : serial_nine_bit_data_regs_tb
